// *** core/scs_clk_mux.sv ***
// Glitch-free selector for clock-enable pulses.
// Assumes every source is a one-cycle enable pulse on clk.
`timescale 1ns/100ps
`default_nettype none

module scs_clk_mux
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [scs_pkg::MUX_N-1:0] src_en,
  input wire logic [2:0] sel,
  output logic out_en
);

  typedef enum logic {SCS_RUN, SCS_HOLD} scs_mux_state_t;

  scs_mux_state_t state;
  scs_mux_state_t next_state;
  logic [2:0] active;
  logic [2:0] next_active;
  logic next_out_en;
  logic new_pulse;

  ////////////////////////////////////////////////////////////////////////
  // A source code past the vector reads as no clock
  assign new_pulse = (sel < 3'(scs_pkg::MUX_N)) ? src_en[sel] : 1'b0;

  // On a change the first pulse of the new source is swallowed, so the
  // gap before the next output is at least one full new period
  always_comb
  begin
    next_state = state;
    next_active = active;
    next_out_en = 1'b0;
    case (state)
      SCS_RUN:
      begin
        if (sel != active)
        begin
          next_active = sel;
          next_state = SCS_HOLD;
        end
        else if (active < 3'(scs_pkg::MUX_N))
        begin
          next_out_en = src_en[active];
        end
      end
      SCS_HOLD:
      begin
        if (sel != active)
        begin
          next_active = sel;
        end
        else if (new_pulse)
        begin
          next_state = SCS_RUN;
        end
      end
      default:
      begin
        next_state = SCS_RUN;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= SCS_RUN;
      active <= scs_pkg::SRC_EMG;
      out_en <= 1'b0;
    end
    else
    begin
      state <= next_state;
      active <= next_active;
      out_en <= next_out_en;
    end
  end

endmodule

`default_nettype wire

// *** core/scs_pkg.sv ***
// Constants shared by the system clock select block: register offsets,
// field positions, reset values, source codes and divide ratios.
// Assumes an 8-bit register port with a 4-bit address.
package scs_pkg;

  // Register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] ADDR_CLOCK_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SYSTEM_MODE = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_BLOCK_STATE = 4'h4;

  // Reset values
  localparam logic [7:0] CLOCK_CONTROL_RST = 8'h00;
  localparam logic [7:0] SYSTEM_MODE_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Clock control register fields
  localparam int CC_EMG_BIT = 7;
  localparam int CC_XTAL_BIT = 6;
  localparam int CC_DSP_HI = 5;
  localparam int CC_DSP_LO = 4;
  localparam int CC_MCU_HI = 3;
  localparam int CC_MCU_LO = 2;
  localparam int CC_FS_HI = 1;
  localparam int CC_FS_LO = 0;

  // Analog system mode register fields
  localparam int SM_IN_HI = 7;
  localparam int SM_IN_LO = 6;
  localparam int SM_PLL_BIT = 5;

  // Interrupt status bits
  localparam int IRQ_FS_BIT = 0;
  localparam int IRQ_TIME_BIT = 1;
  localparam int IRQ_STALL_BIT = 2;

  // Input-clock select patterns and division ratios
  localparam logic [1:0] IN_SEL_DIV1 = 2'h0;
  localparam logic [1:0] IN_SEL_DIV2 = 2'h1;
  localparam logic [1:0] IN_SEL_DIV4 = 2'h2;
  localparam logic [2:0] RATIO_1 = 3'h1;
  localparam logic [2:0] RATIO_2 = 3'h2;
  localparam logic [2:0] RATIO_4 = 3'h4;

  // Clock multiplexer source codes
  localparam int MUX_N = 6;
  localparam logic [2:0] SRC_PLL0 = 3'h0;
  localparam logic [2:0] SRC_PLL1 = 3'h1;
  localparam logic [2:0] SRC_PLL2 = 3'h2;
  localparam logic [2:0] SRC_PLL3 = 3'h3;
  localparam logic [2:0] SRC_EMG = 3'h4;
  localparam logic [2:0] SRC_NONE = 3'h5;

  // Event divider width and frame-event ratios
  localparam int EVT_W = 14;
  localparam logic [13:0] FS_DIV_16 = 14'h0010;
  localparam logic [13:0] FS_DIV_8 = 14'h0008;
  localparam logic [13:0] FS_DIV_4 = 14'h0004;
  localparam logic [13:0] FS_DIV_1 = 14'h0001;

  // Time event: frames per event (8 kHz frames, one second)
  localparam logic [13:0] TIME_EVENT_FRAMES = 14'h1F40;

endpackage

// *** core/scs_pulse_div.sv ***
// Pulse divider: one output pulse per 'ratio' input pulses.
// Assumes in_en is a one-cycle pulse and ratio is at least one.
`timescale 1ns/100ps
`default_nettype none

module scs_pulse_div
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_en,
  input wire logic [scs_pkg::EVT_W-1:0] ratio,
  output logic out_pulse
);

  logic [scs_pkg::EVT_W-1:0] cnt;
  logic [scs_pkg::EVT_W-1:0] next_cnt;
  logic next_out_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Terminal test uses >= so a lowered ratio never strands the counter
  always_comb
  begin
    next_cnt = cnt;
    next_out_pulse = 1'b0;
    if (in_en)
    begin
      if ((cnt + 1'b1) >= ratio)
      begin
        next_cnt = '0;
        next_out_pulse = 1'b1;
      end
      else
      begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt <= '0;
      out_pulse <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      out_pulse <= next_out_pulse;
    end
  end

endmodule

`default_nettype wire

// *** core/scs_top.sv ***
// System clock select: input divider, MCU/DSP/CODEC clock selection,
// frame-sync and time events, register port and interrupt.
// Assumes all clocks arrive as one-cycle enable pulses on clk.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module scs_top
#(
  parameter logic [13:0] TIME_FRAMES = scs_pkg::TIME_EVENT_FRAMES
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [scs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [scs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [scs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic xtal_en,
  input wire logic emergency_clock,
  input wire logic pll_clk1_en,
  input wire logic pll_clk7_en,
  input wire logic pll_clk14_en,
  input wire logic pll_clk21_en,
  input wire logic pll_clk28_en,
  input wire logic pll_clk42_en,
  input wire logic freq_corrected_codec_clock,
  input wire logic phase_corrected_codec_clock,
  input wire logic codec_frame_clock,
  output logic pll_ref_en,
  output logic [2:0] input_div_ratio,
  output logic pll_on,
  output logic crystal_358,
  output logic freq_correction_en,
  output logic iom_master_only,
  output logic peripherals_guaranteed,
  output logic mcu_stalled,
  output logic mcu_clk_en,
  output logic dsp_clk_en,
  output logic codec_clk_en,
  output logic frame_sync_event,
  output logic time_event,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Input-clock select to division ratio; the unlisted pattern stays at 1
  function automatic logic [2:0] div_of(input logic [1:0] s);
    case (s)
      scs_pkg::IN_SEL_DIV1: div_of = scs_pkg::RATIO_1;
      scs_pkg::IN_SEL_DIV2: div_of = scs_pkg::RATIO_2;
      scs_pkg::IN_SEL_DIV4: div_of = scs_pkg::RATIO_4;
      default: div_of = scs_pkg::RATIO_1;
    endcase
  endfunction

  // Frame-sync select to frame divide ratio
  function automatic logic [13:0] fs_ratio(input logic [1:0] s);
    case (s)
      2'h0: fs_ratio = scs_pkg::FS_DIV_16;
      2'h1: fs_ratio = scs_pkg::FS_DIV_8;
      2'h2: fs_ratio = scs_pkg::FS_DIV_4;
      default: fs_ratio = scs_pkg::FS_DIV_1;
    endcase
  endfunction

  // Common source pick for the MCU and DSP multiplexers
  function automatic logic [2:0] pick(input logic emg, input logic pll,
                                      input logic [1:0] s);
    if (!emg)
      pick = scs_pkg::SRC_EMG;
    else if (!pll)
      pick = scs_pkg::SRC_NONE;
    else
      pick = {1'b0, s};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] clock_control_reg;
  logic [7:0] analog_system_mode_reg;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [7:0] next_clock_control_reg;
  logic [7:0] next_analog_system_mode_reg;
  logic [2:0] next_irq_status;
  logic [2:0] next_irq_mask;
  logic [7:0] next_reg_rdata;
  logic next_irq;
  logic [2:0] events;
  logic [2:0] w1c;
  logic emergency_mode_bit;
  logic stall_now;
  logic stall_q;
  logic fs_pulse;
  logic time_pulse;

  assign emergency_mode_bit = clock_control_reg[scs_pkg::CC_EMG_BIT];
  assign stall_now = emergency_mode_bit
                     & ~analog_system_mode_reg[scs_pkg::SM_PLL_BIT];

  // Events that set sticky status bits; stall only on its onset
  assign events[scs_pkg::IRQ_FS_BIT] = fs_pulse;
  assign events[scs_pkg::IRQ_TIME_BIT] = time_pulse;
  assign events[scs_pkg::IRQ_STALL_BIT] = stall_now & ~stall_q;
  assign w1c = (reg_wr && reg_addr == scs_pkg::ADDR_IRQ_STATUS)
               ? reg_wdata[2:0] : 3'h0;

  // Register writes, reads and interrupt; a set beats a same-cycle clear
  always_comb
  begin
    next_clock_control_reg = clock_control_reg;
    next_analog_system_mode_reg = analog_system_mode_reg;
    next_irq_mask = irq_mask;
    next_reg_rdata = 8'h00;
    if (reg_wr)
    begin
      case (reg_addr)
        scs_pkg::ADDR_CLOCK_CONTROL: next_clock_control_reg = reg_wdata;
        scs_pkg::ADDR_SYSTEM_MODE: next_analog_system_mode_reg = reg_wdata;
        scs_pkg::ADDR_IRQ_MASK: next_irq_mask = reg_wdata[2:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        scs_pkg::ADDR_CLOCK_CONTROL: next_reg_rdata = clock_control_reg;
        scs_pkg::ADDR_SYSTEM_MODE: next_reg_rdata = analog_system_mode_reg;
        scs_pkg::ADDR_IRQ_STATUS: next_reg_rdata = {5'h00, irq_status};
        scs_pkg::ADDR_IRQ_MASK: next_reg_rdata = {5'h00, irq_mask};
        scs_pkg::ADDR_BLOCK_STATE:
          next_reg_rdata = {2'h0, mcu_stalled, peripherals_guaranteed,
                            freq_correction_en, input_div_ratio};
        default: next_reg_rdata = 8'h00;
      endcase
    end
    next_irq_status = (irq_status & ~w1c) | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // Register file; the clock control register clears to emergency mode
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      clock_control_reg <= scs_pkg::CLOCK_CONTROL_RST;
      analog_system_mode_reg <= scs_pkg::SYSTEM_MODE_RST;
      irq_status <= scs_pkg::IRQ_RST;
      irq_mask <= scs_pkg::IRQ_RST;
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      stall_q <= 1'b0;
    end
    else
    begin
      clock_control_reg <= next_clock_control_reg;
      analog_system_mode_reg <= next_analog_system_mode_reg;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_reg_rdata;
      irq <= next_irq;
      stall_q <= stall_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input clock pre-divider and mode outputs
  logic [1:0] pre_cnt;
  logic [1:0] next_pre_cnt;
  logic next_pll_ref_en;
  logic [2:0] ratio_now;
  logic xtal_358;

  assign ratio_now = div_of(analog_system_mode_reg[scs_pkg::SM_IN_HI:
                                                   scs_pkg::SM_IN_LO]);
  assign xtal_358 = clock_control_reg[scs_pkg::CC_XTAL_BIT];

  // Ratio 1 passes every crystal pulse straight through to the PLL
  always_comb
  begin
    next_pre_cnt = pre_cnt;
    next_pll_ref_en = 1'b0;
    if (xtal_en)
    begin
      if ({1'b0, pre_cnt} + 3'h1 >= ratio_now)
      begin
        next_pre_cnt = 2'h0;
        next_pll_ref_en = 1'b1;
      end
      else
      begin
        next_pre_cnt = pre_cnt + 2'h1;
      end
    end
  end

  // Divider and mode flags; emergency mode withdraws the guarantee
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pre_cnt <= 2'h0;
      pll_ref_en <= 1'b0;
      input_div_ratio <= scs_pkg::RATIO_1;
      pll_on <= 1'b0;
      crystal_358 <= 1'b0;
      freq_correction_en <= 1'b0;
      iom_master_only <= 1'b0;
      peripherals_guaranteed <= 1'b0;
      mcu_stalled <= 1'b0;
    end
    else
    begin
      pre_cnt <= next_pre_cnt;
      pll_ref_en <= next_pll_ref_en;
      input_div_ratio <= ratio_now;
      pll_on <= analog_system_mode_reg[scs_pkg::SM_PLL_BIT];
      crystal_358 <= xtal_358;
      freq_correction_en <= xtal_358;
      iom_master_only <= xtal_358;
      peripherals_guaranteed <= emergency_mode_bit;
      mcu_stalled <= stall_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock multiplexers
  logic [2:0] mcu_sel;
  logic [2:0] dsp_sel;
  logic [2:0] codec_sel;
  logic [scs_pkg::MUX_N-1:0] mcu_src;
  logic [scs_pkg::MUX_N-1:0] dsp_src;
  logic [scs_pkg::MUX_N-1:0] codec_src;

  // Source vectors: pll codes 0..3 (codec: corrected clocks 0..1, dead 2..3), emergency, then a dead input
  assign mcu_src = {1'b0, emergency_clock, pll_clk21_en, pll_clk14_en,
                    pll_clk7_en, pll_clk1_en};
  assign dsp_src = {1'b0, emergency_clock, pll_clk28_en, pll_clk42_en,
                    pll_clk7_en, pll_clk1_en};
  assign codec_src = {1'b0, emergency_clock, 2'h0,
                      phase_corrected_codec_clock,
                      freq_corrected_codec_clock};

  // Select bits are ignored unless the emergency bit is set and the PLL is on
  assign mcu_sel = pick(emergency_mode_bit, pll_on,
                        clock_control_reg[scs_pkg::CC_MCU_HI:
                                          scs_pkg::CC_MCU_LO]);
  assign dsp_sel = pick(emergency_mode_bit, pll_on,
                        clock_control_reg[scs_pkg::CC_DSP_HI:
                                          scs_pkg::CC_DSP_LO]);

  // Phase correction runs off the 21 MHz PLL clock, so no PLL, no clock
  always_comb
  begin
    if (!emergency_mode_bit)
      codec_sel = scs_pkg::SRC_EMG;
    else if (xtal_358)
      codec_sel = scs_pkg::SRC_PLL0;
    else if (pll_on)
      codec_sel = scs_pkg::SRC_PLL1;
    else
      codec_sel = scs_pkg::SRC_NONE;
  end

  scs_clk_mux u_mcu_mux
  (
    .clk(clk),
    .rstn(rstn),
    .src_en(mcu_src),
    .sel(mcu_sel),
    .out_en(mcu_clk_en)
  );

  scs_clk_mux u_dsp_mux
  (
    .clk(clk),
    .rstn(rstn),
    .src_en(dsp_src),
    .sel(dsp_sel),
    .out_en(dsp_clk_en)
  );

  scs_clk_mux u_codec_mux
  (
    .clk(clk),
    .rstn(rstn),
    .src_en(codec_src),
    .sel(codec_sel),
    .out_en(codec_clk_en)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame-locked events; both count codec frame clock pulses only
  scs_pulse_div u_fs_div
  (
    .clk(clk),
    .rstn(rstn),
    .in_en(codec_frame_clock),
    .ratio(fs_ratio(clock_control_reg[scs_pkg::CC_FS_HI:
                                      scs_pkg::CC_FS_LO])),
    .out_pulse(fs_pulse)
  );

  scs_pulse_div u_time_div
  (
    .clk(clk),
    .rstn(rstn),
    .in_en(codec_frame_clock),
    .ratio(TIME_FRAMES),
    .out_pulse(time_pulse)
  );

  // One more register stage keeps the event outputs on flip-flops
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      frame_sync_event <= 1'b0;
      time_event <= 1'b0;
    end
    else
    begin
      frame_sync_event <= fs_pulse;
      time_event <= time_pulse;
    end
  end

endmodule

`default_nettype wire

// *** tb/scs_clk_src.sv ***
// Clock source model: crystal, emergency, PLL, CODEC and frame enables.
// Assumes the PLL only runs while the block reports pll_on.
`timescale 1ns/100ps
`default_nettype none

module scs_clk_src
(
  input wire logic clk,
  input wire logic pll_on,
  output logic [11:0] src
);
  // Periods differ except for sources 0 and 6 (both 3), so the bench can tell the others apart by pulse count
  localparam int PER [11] = '{3, 6, 11, 7, 5, 4, 3, 2, 9, 8, 10};
  logic [11:0] q = 12'h000;
  logic [11:0] next_q;
  logic [15:0] cnt = 16'h0000;

  assign src = q;

  // Bit 11 stays low: the reference for a mux that selects nothing
  always_comb
  begin
    next_q = 12'h000;
    for (int i = 0; i < 11; i++)
      next_q[i] = (cnt % PER[i]) == 0;
    // PLL clocks, and the phase-corrected clock built on them, stop
    if (!pll_on)
    begin
      next_q[7:2] = 6'h00;
      next_q[9] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    q <= next_q;
    cnt <= cnt + 16'h0001;
  end
endmodule
`default_nettype wire

// *** tb/scs_monitor.sv ***
// Checker of clock routing, divider and event timing at the top ports.
// Assumes source enables are never high on two cycles in a row.
`timescale 1ns/100ps
`default_nettype none

module scs_monitor
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic xtal_en,
  input wire logic emergency_clock,
  input wire logic freq_corrected_codec_clock,
  input wire logic codec_frame_clock,
  input wire logic pll_ref_en,
  input wire logic [2:0] input_div_ratio,
  input wire logic pll_on,
  input wire logic crystal_358,
  input wire logic freq_correction_en,
  input wire logic iom_master_only,
  input wire logic peripherals_guaranteed,
  input wire logic mcu_stalled,
  input wire logic mcu_clk_en,
  input wire logic dsp_clk_en,
  input wire logic codec_clk_en,
  input wire logic frame_sync_event,
  input wire logic irq
);
  logic [4:0] quiet;
  logic [4:0] next_quiet;
  logic settled;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  assign settled = quiet == 5'h1F;

  // Cycles since a write; muxes swallow a pulse right after a switch
  always_comb
  begin
    next_quiet = quiet;
    if (!rstn || reg_wr)
      next_quiet = 5'h00;
    else if (!settled)
      next_quiet = quiet + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    quiet <= next_quiet;
  end

  ////////////////////////////////////////////////////////////////////////
  ratio_after_reset_a: assert property (
    $rose(rstn) |-> input_div_ratio == 3'h1) else $error("ratio not one");
  ref_undivided_a: assert property (
    settled && input_div_ratio == 3'h1 |-> pll_ref_en == $past(xtal_en))
    else $error("reference divided");
  mcu_emg_route_a: assert property (
    settled && !peripherals_guaranteed
    |-> mcu_clk_en == $past(emergency_clock)) else $error("mcu source");
  codec_emg_route_a: assert property (
    settled && !peripherals_guaranteed
    |-> codec_clk_en == $past(emergency_clock)) else $error("codec source");
  codec_corrected_a: assert property (
    settled && peripherals_guaranteed && crystal_358
    |-> codec_clk_en == $past(freq_corrected_codec_clock))
    else $error("codec correction");
  mcu_stall_flag_a: assert property (
    settled |-> mcu_stalled == (peripherals_guaranteed && !pll_on))
    else $error("stall flag");
  stall_no_clock_a: assert property (
    settled && mcu_stalled |-> !mcu_clk_en && !dsp_clk_en)
    else $error("clock while stalled");
  xtal_flags_a: assert property (
    crystal_358 == freq_correction_en && crystal_358 == iom_master_only)
    else $error("crystal flags");
  fs_frame_sync_a: assert property (
    frame_sync_event |-> $past(codec_frame_clock, 2))
    else $error("frame event off frame");
  mux_no_runt_a: assert property (
    3'h0 == ({mcu_clk_en, dsp_clk_en, codec_clk_en}
    & $past({mcu_clk_en, dsp_clk_en, codec_clk_en}))) else $error("runt");

  stall_c: cover property ($rose(mcu_stalled));
  fs_c: cover property (frame_sync_event);
  irq_c: cover property ($rose(irq));
endmodule

bind scs_top scs_monitor mon_u
(
  .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .xtal_en(xtal_en),
  .emergency_clock(emergency_clock),
  .freq_corrected_codec_clock(freq_corrected_codec_clock),
  .codec_frame_clock(codec_frame_clock), .pll_ref_en(pll_ref_en),
  .input_div_ratio(input_div_ratio), .pll_on(pll_on),
  .crystal_358(crystal_358), .freq_correction_en(freq_correction_en),
  .iom_master_only(iom_master_only),
  .peripherals_guaranteed(peripherals_guaranteed),
  .mcu_stalled(mcu_stalled), .mcu_clk_en(mcu_clk_en),
  .dsp_clk_en(dsp_clk_en), .codec_clk_en(codec_clk_en),
  .frame_sync_event(frame_sync_event), .irq(irq)
);
`default_nettype wire

// *** tb/system_clock_select_test.sv ***
// Bench of the clock select block: registers, routing, divider, events.
// Assumes the clock source model drives every clock enable input.
`timescale 1ns/100ps
`default_nettype none

module system_clock_select_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [11:0] src;
  wire [5:0] outs;
  logic [2:0] ratio;
  logic pll_on, xtal358, fcorr, iom_m, guar, stall, irq;
  logic [15:0] fs_n [4] = '{16'h0010, 16'h0008, 16'h0004, 16'h0001};
  int miscompares = 0;
  int n_tests = 0;

  initial
    forever #2 clk = ~clk;

  scs_clk_src src_u (.clk(clk), .pll_on(pll_on), .src(src));

  scs_top #(.TIME_FRAMES(14'h0004)) dut_u
  (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xtal_en(src[0]), .emergency_clock(src[1]), .pll_clk1_en(src[2]),
    .pll_clk7_en(src[3]), .pll_clk14_en(src[4]), .pll_clk21_en(src[5]),
    .pll_clk28_en(src[6]), .pll_clk42_en(src[7]),
    .freq_corrected_codec_clock(src[8]),
    .phase_corrected_codec_clock(src[9]), .codec_frame_clock(src[10]),
    .pll_ref_en(outs[3]), .input_div_ratio(ratio), .pll_on(pll_on),
    .crystal_358(xtal358), .freq_correction_en(fcorr),
    .iom_master_only(iom_m), .peripherals_guaranteed(guar),
    .mcu_stalled(stall), .mcu_clk_en(outs[0]), .dsp_clk_en(outs[1]),
    .codec_clk_en(outs[2]), .frame_sync_event(outs[4]),
    .time_event(outs[5]), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle strobes launched just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] m,
    input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, reg_rdata & m}, {8'h00, exp});
  endtask

  // Output j must copy source i one cycle late once the mux has settled
  task automatic meas(input int i, input int j);
    logic [15:0] s;
    logic [15:0] o;
    s = 16'h0000;
    o = 16'h0000;
    repeat (40) @(negedge clk);
    repeat (200)
    begin
      s += {15'h0000, src[i]};
      @(negedge clk);
      o += {15'h0000, outs[j]};
    end
    chk(o, s);
  endtask

  // Source i pulses between the 2nd and 3rd pulse of output j
  task automatic gap(input int i, input int j, input logic [15:0] exp);
    logic [15:0] c;
    int k;
    c = 16'h0000;
    k = 0;
    for (int e = 0; e < 3; e++)
    begin
      @(negedge clk);
      c = 16'h0000;
      while (outs[j] !== 1'b1 && k < 3000)
      begin
        @(negedge clk);
        c += {15'h0000, src[i]};
        k++;
      end
    end
    if (k >= 3000)
    begin
      miscompares++;
      wrap_up();
    end
    else
    begin
      chk(c, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; a write settles before any routing is measured
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h0, 8'hFF, 8'h00);
    rd(4'h1, 8'hFF, 8'h00);
    rd(4'h3, 8'hFF, 8'h00);
    chk({13'h0000, ratio}, 16'h0001);
    chk({15'h0000, guar}, 16'h0000);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'hFF, 8'h00);
    wr(4'h4, 8'hFF);
    rd(4'h4, 8'hFF, 8'h01);
    // Select bits set while the emergency bit is clear have no effect
    wr(4'h0, 8'h7C);
    meas(1, 0);
    meas(1, 1);
    meas(1, 2);
    chk({13'h0000, xtal358, fcorr, iom_m}, 16'h0007);
    for (int p = 0; p < 3; p++)
    begin
      wr(4'h1, 8'h20 | (8'(p) << 6));
      gap(0, 3, 16'h0001 << p);
      chk({13'h0000, ratio}, 16'h0001 << p);
    end
    // PLL is already on before the emergency bit is set
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h0, 8'h80 | (8'(k & 1) << 6) | (8'(k) * 8'h14));
      meas(2 + k, 0);
      meas(k < 2 ? 2 + k : 9 - k, 1);
      meas(9 - (k & 1), 2);
    end
    rd(4'h0, 8'hFF, 8'hFC);
    chk({15'h0000, guar}, 16'h0001);
    // PLL off in normal mode: MCU, DSP and CODEC clocks stop, stall interrupt fires
    wr(4'h0, 8'hBC);
    wr(4'h3, 8'h04);
    wr(4'h1, 8'h00);
    meas(11, 0);
    meas(11, 1);
    meas(11, 2);
    chk({14'h0000, stall, irq}, 16'h0003);
    rd(4'h4, 8'hFF, 8'h31);
    rd(4'h2, 8'h04, 8'h04);
    wr(4'h2, 8'h04);
    rd(4'h2, 8'h04, 8'h00);
    chk({15'h0000, irq}, 16'h0000);
    wr(4'h3, 8'h01);
    rd(4'h2, 8'h01, 8'h01);
    chk({15'h0000, irq}, 16'h0001);
    wr(4'h3, 8'h00);
    rd(4'h3, 8'hFF, 8'h00);
    chk({15'h0000, irq}, 16'h0000);
    // Unlisted input select reads as ratio one
    wr(4'h1, 8'h80);
    wr(4'h1, 8'hC0);
    rd(4'h4, 8'h07, 8'h01);
    wr(4'h1, 8'h80);
    // Reset again mid-run: ratio and registers fall back to defaults
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h1, 8'hFF, 8'h00);
    rd(4'h0, 8'hFF, 8'h00);
    chk({13'h0000, ratio}, 16'h0001);
    // Event rates in frame pulses
    wr(4'h1, 8'h20);
    for (int s = 0; s < 4; s++)
    begin
      wr(4'h0, 8'(s));
      gap(10, 4, fs_n[s]);
    end
    gap(10, 5, 16'h0004);
    wrap_up();
  end
endmodule
`default_nettype wire
